// File: rtl/fsp_map.svh
// fsp_map.svh: offsets, field positions, reset values and timing counts of the
// flash self-program sequencer; definitions only, included by every rtl file.
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH
`define FSP_AW 4
`define FSP_ADDR_CTRL 4'h0
`define FSP_ADDR_STAT 4'h1
`define FSP_CTRL_RST 8'h00
`define FSP_BIT_EN 0
`define FSP_BIT_ERASE 1
`define FSP_BIT_WRITE 2
`define FSP_BIT_LFSEL 3
`define FSP_BIT_RRE 4
`define FSP_BIT_IRQEN 7
`define FSP_CMD_ERASE 8'h03
`define FSP_CMD_LOAD 8'h01
`define FSP_CMD_WRITE 8'h05
`define FSP_SPM_WIN 3'h4
`define FSP_LPM_WIN 3'h3
`define FSP_Z_FLB 16'h0000
`define FSP_Z_LOCK 16'h0001
`define FSP_Z_EFB 16'h0002
`define FSP_Z_FHB 16'h0003
`define FSP_WORD_W 5
`define FSP_PAGE_W 6
`define FSP_CLK_NS 50
`define FSP_OP_MIN_NS 3700000
`define FSP_OP_MAX_NS 4500000
`define FSP_OP_CYCLES ((`FSP_OP_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`endif

// File: rtl/fsp_pkg.sv
// fsp_pkg: types shared by the sequencer and its surroundings.
// assumes fsp_map.svh is on the include path.
`include "fsp_map.svh"
package fsp_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_PROG, ST_WAIT} fsp_state_e;
    // one flash programming command towards the array
    typedef struct packed {
        logic erase;
        logic write;
        logic [`FSP_PAGE_W-1:0] page;
        logic [`FSP_WORD_W-1:0] word;
        logic [15:0] data;
    } fsp_flash_s;
    // fuse and lock bytes, one bit per fuse, 1 = programmed
    typedef struct packed {
        logic [7:0] lock;
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] ext;
    } fsp_fuse_s;
endpackage

// File: rtl/fsp_seq.sv
// fsp_seq: self-programming sequencer of the on-chip program flash.
// assumes a cpu that pulses store/load strobes for one cycle and obeys the stall,
// and a flash array that returns the word at z_ptr_i[15:1] in the same cycle.
//
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.svh"
module fsp_seq #(
    parameter int OP_CYCLES = `FSP_OP_CYCLES,
    parameter int PAGE_WORDS = 1 << `FSP_WORD_W
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // register port
    input wire logic [`FSP_AW-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [7:0] reg_rdata_o,
    // cpu side
    input wire logic spm_exec_i,
    input wire logic lpm_exec_i,
    input wire logic [15:0] z_ptr_i,
    input wire logic [15:0] data_word_pair_i,
    input wire logic global_irq_en_i,
    output logic cpu_stall_o,
    output logic [7:0] lpm_data_o,
    output logic self_prog_ready_irq_o,
    // flash array, eeprom and fuses
    input wire logic [15:0] flash_rdata_i,
    input wire logic eeprom_write_busy_i,
    input wire fsp_pkg::fsp_fuse_s fuse_prog_i,
    output fsp_pkg::fsp_flash_s flash_cmd_o
);
    import fsp_pkg::*;

    localparam int TW = $clog2(OP_CYCLES + 1);
    localparam logic [TW-1:0] OP_LAST = TW'(OP_CYCLES - 1);

    // ****************************************************************
    // control register and command windows
    // ****************************************************************
    logic [7:0] prog_mem_ctrl_status, next_ctrl;
    logic [2:0] spm_win, next_spm_win;
    logic [2:0] lpm_win, next_lpm_win;
    logic ee_busy_q, next_ee_busy_q;
    fsp_state_e state, next_state;
    logic [TW-1:0] timer, next_timer;
    logic [`FSP_WORD_W-1:0] idx, next_idx;
    logic [`FSP_PAGE_W-1:0] op_page, next_op_page;
    logic [PAGE_WORDS-1:0] buf_valid, next_buf_valid;
    logic [15:0] page_buf [PAGE_WORDS];
    logic buf_we;
    logic ctrl_wr, spm_ok, lf_mode, op_done;

    // word address split: low bits pick the word, high bits the page
    function automatic logic [`FSP_WORD_W-1:0] word_of(input logic [15:0] z);
        return z[`FSP_WORD_W:1];
    endfunction
    function automatic logic [`FSP_PAGE_W-1:0] page_of(input logic [15:0] z);
        return z[`FSP_WORD_W+`FSP_PAGE_W:`FSP_WORD_W+1];
    endfunction

    // while the eeprom writes nothing of ours may start
    assign ctrl_wr = reg_we_i && reg_addr_i == `FSP_ADDR_CTRL && !eeprom_write_busy_i;
    assign lf_mode = prog_mem_ctrl_status[`FSP_BIT_LFSEL] && prog_mem_ctrl_status[`FSP_BIT_EN];
    assign spm_ok = spm_exec_i && spm_win != 3'h0 && !eeprom_write_busy_i && !lf_mode;
    assign op_done = (state == ST_ERASE || state == ST_WAIT) && timer == OP_LAST;

    always_comb begin
        next_ctrl = prog_mem_ctrl_status;
        next_spm_win = spm_win;
        next_lpm_win = lpm_win;
        buf_we = 1'b0;
        next_buf_valid = buf_valid;
        next_ee_busy_q = eeprom_write_busy_i;
        if (spm_win != 3'h0) begin
            next_spm_win = spm_win - 3'h1;
        end
        if (lpm_win != 3'h0) begin
            next_lpm_win = lpm_win - 3'h1;
        end
        // a window that runs out unused drops the command
        if ((spm_win == 3'h1 && !spm_exec_i && !lf_mode) ||
            (lpm_win == 3'h1 && !lpm_exec_i && lf_mode)) begin
            next_ctrl[`FSP_BIT_EN] = 1'b0;
            next_ctrl[`FSP_BIT_ERASE] = 1'b0;
            next_ctrl[`FSP_BIT_WRITE] = 1'b0;
            next_ctrl[`FSP_BIT_LFSEL] = 1'b0;
        end
        if (lpm_exec_i && lf_mode && lpm_win != 3'h0 && !eeprom_write_busy_i) begin
            next_ctrl[`FSP_BIT_EN] = 1'b0;
            next_ctrl[`FSP_BIT_LFSEL] = 1'b0;
            next_lpm_win = 3'h0;
        end
        if (spm_ok) begin
            next_spm_win = 3'h0;
            if (prog_mem_ctrl_status == `FSP_CMD_LOAD) begin
                buf_we = 1'b1;
                next_buf_valid[word_of(z_ptr_i)] = 1'b1;
                next_ctrl[`FSP_BIT_EN] = 1'b0;
            end
        end
        if (op_done) begin
            next_ctrl[`FSP_BIT_EN] = 1'b0;
            next_ctrl[`FSP_BIT_ERASE] = 1'b0;
            next_ctrl[`FSP_BIT_WRITE] = 1'b0;
            if (state == ST_WAIT) begin
                next_buf_valid = '0;
            end
        end
        // the eeprom starting a write throws away what has been loaded
        if (eeprom_write_busy_i && !ee_busy_q) begin
            next_buf_valid = '0;
        end
        if (ctrl_wr && state == ST_IDLE) begin
            next_ctrl = reg_wdata_i;
            next_ctrl[`FSP_BIT_RRE] = 1'b0;
            next_spm_win = 3'h0;
            next_lpm_win = 3'h0;
            if (reg_wdata_i[`FSP_BIT_RRE]) begin
                next_buf_valid = '0;
                next_ctrl[`FSP_BIT_EN] = 1'b0;
            end else if (reg_wdata_i[`FSP_BIT_EN]) begin
                next_spm_win = `FSP_SPM_WIN;
                if (reg_wdata_i[`FSP_BIT_LFSEL]) begin
                    next_lpm_win = `FSP_LPM_WIN;
                    next_spm_win = 3'h0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prog_mem_ctrl_status <= `FSP_CTRL_RST;
            spm_win <= 3'h0;
            lpm_win <= 3'h0;
            buf_valid <= '0;
            ee_busy_q <= 1'b0;
        end else begin
            prog_mem_ctrl_status <= next_ctrl;
            spm_win <= next_spm_win;
            lpm_win <= next_lpm_win;
            buf_valid <= next_buf_valid;
            ee_busy_q <= next_ee_busy_q;
        end
    end

    // buffer words carry no reset; the valid vector decides what counts
    always_ff @(posedge sys_clk_i) begin
        if (buf_we) begin
            page_buf[word_of(z_ptr_i)] <= data_word_pair_i;
        end
    end

    // ****************************************************************
    // erase and write sequence
    // ****************************************************************
    fsp_flash_s next_flash;
    logic next_stall;

    always_comb begin
        next_state = state;
        next_timer = timer;
        next_idx = idx;
        next_op_page = op_page;
        next_flash = '0;
        case (state)
            ST_IDLE: begin
                next_timer = '0;
                next_idx = '0;
                if (spm_ok && prog_mem_ctrl_status == `FSP_CMD_ERASE) begin
                    next_op_page = page_of(z_ptr_i);
                    next_state = ST_ERASE;
                end else if (spm_ok && prog_mem_ctrl_status == `FSP_CMD_WRITE) begin
                    next_op_page = page_of(z_ptr_i);
                    next_state = ST_PROG;
                end
            end
            ST_ERASE: begin
                // buffer is left alone here so it survives the erase
                next_flash.erase = 1'b1;
                next_flash.page = op_page;
                next_timer = timer + TW'(1);
                if (op_done) begin
                    next_state = ST_IDLE;
                end
            end
            ST_PROG: begin
                // hand each word to the array; unloaded words stay erased
                next_flash.write = 1'b1;
                next_flash.page = op_page;
                next_flash.word = idx;
                next_flash.data = buf_valid[idx] ? page_buf[idx] : 16'hFFFF;
                next_timer = timer + TW'(1);
                next_idx = idx + `FSP_WORD_W'(1);
                if (idx == `FSP_WORD_W'(PAGE_WORDS - 1)) begin
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                next_timer = timer + TW'(1);
                if (op_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_stall = next_state != ST_IDLE;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= ST_IDLE;
            timer <= '0;
            idx <= '0;
            op_page <= '0;
            flash_cmd_o <= '0;
            cpu_stall_o <= 1'b0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            idx <= next_idx;
            op_page <= next_op_page;
            flash_cmd_o <= next_flash;
            cpu_stall_o <= next_stall;
        end
    end

    // ****************************************************************
    // load path, register read, ready interrupt
    // ****************************************************************
    logic [7:0] next_lpm, next_rdata;
    logic next_irq;

    always_comb begin
        next_lpm = z_ptr_i[0] ? flash_rdata_i[15:8] : flash_rdata_i[7:0];
        if (lf_mode && lpm_win != 3'h0 && !eeprom_write_busy_i) begin
            case (z_ptr_i)
                `FSP_Z_FLB: next_lpm = ~fuse_prog_i.low;
                `FSP_Z_LOCK: next_lpm = ~fuse_prog_i.lock;
                `FSP_Z_EFB: next_lpm = ~fuse_prog_i.ext;
                `FSP_Z_FHB: next_lpm = ~fuse_prog_i.high;
                default: next_lpm = 8'hFF;
            endcase
        end
        if (!lpm_exec_i) begin
            next_lpm = lpm_data_o;
        end
        case (reg_addr_i)
            `FSP_ADDR_CTRL: next_rdata = prog_mem_ctrl_status;
            `FSP_ADDR_STAT: next_rdata = {5'h00, |buf_valid, eeprom_write_busy_i, state != ST_IDLE};
            default: next_rdata = 8'h00;
        endcase
        if (!reg_re_i) begin
            next_rdata = 8'h00;
        end
        next_irq = prog_mem_ctrl_status[`FSP_BIT_IRQEN] && global_irq_en_i &&
                   !next_ctrl[`FSP_BIT_EN] && !eeprom_write_busy_i &&
                   next_state == ST_IDLE;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lpm_data_o <= 8'h00;
            reg_rdata_o <= 8'h00;
            self_prog_ready_irq_o <= 1'b0;
        end else begin
            lpm_data_o <= next_lpm;
            reg_rdata_o <= next_rdata;
            self_prog_ready_irq_o <= next_irq;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    erase_start_a: assert property (
        (state == ST_IDLE && spm_ok && prog_mem_ctrl_status == `FSP_CMD_ERASE)
        |=> state == ST_ERASE ##1 flash_cmd_o.erase)
        else $error("erase did not start");
    erase_stall_a: assert property (
        state == ST_ERASE |-> cpu_stall_o)
        else $error("cpu not stalled in erase");
    write_stall_a: assert property (
        (state == ST_PROG || state == ST_WAIT) |-> cpu_stall_o)
        else $error("cpu not stalled in write");
    load_store_a: assert property (
        buf_we |=> buf_valid[word_of($past(z_ptr_i))] &&
        page_buf[word_of($past(z_ptr_i))] == $past(data_word_pair_i))
        else $error("buffer word not stored");
    write_clear_a: assert property (
        (state == ST_WAIT && op_done) |=> buf_valid == '0)
        else $error("buffer not cleared after write");
    window_cancel_a: assert property (
        (ctrl_wr && state == ST_IDLE && reg_wdata_i == `FSP_CMD_ERASE)
        ##1 !spm_exec_i [*4] |=> !prog_mem_ctrl_status[`FSP_BIT_EN] && state == ST_IDLE)
        else $error("stale command not cancelled");
    ee_block_a: assert property (
        (eeprom_write_busy_i && state == ST_IDLE) |=> state == ST_IDLE && !cpu_stall_o)
        else $error("store accepted during eeprom write");
    ee_discard_a: assert property (
        $rose(eeprom_write_busy_i) |=> buf_valid == '0)
        else $error("buffer kept across eeprom write");
    lock_read_a: assert property (
        (lf_mode && lpm_win != 3'h0 && lpm_exec_i && !eeprom_write_busy_i &&
         z_ptr_i == `FSP_Z_LOCK) |=> lpm_data_o == ~$past(fuse_prog_i.lock))
        else $error("lock bits misread");
    op_time_a: assert property (
        (state != ST_IDLE && timer != OP_LAST) |=> state != ST_IDLE)
        else $error("operation ended early");

    // stalled cycles counted apart from the sequencer timer, so a timer
    // fault cannot hide behind itself
    logic [TW-1:0] stall_len, next_stall_len;
    always_comb begin
        next_stall_len = cpu_stall_o ? stall_len + TW'(1) : '0;
    end
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stall_len <= '0;
        end else begin
            stall_len <= next_stall_len;
        end
    end
    op_length_a: assert property (
        $fell(cpu_stall_o) |-> stall_len == TW'(OP_CYCLES))
        else $error("operation length wrong");
    done_clear_a: assert property (
        op_done |=> !prog_mem_ctrl_status[`FSP_BIT_EN] && !cpu_stall_o)
        else $error("enable not cleared at completion");

    erase_cov_c: cover property (state == ST_ERASE && op_done);
    write_cov_c: cover property (state == ST_WAIT && op_done);
    fuse_cov_c: cover property (lf_mode && lpm_exec_i && lpm_win != 3'h0);
    cancel_cov_c: cover property (spm_win == 3'h1 && !spm_exec_i);
    load_cov_c: cover property (buf_we);
endmodule
`default_nettype wire

// File: tb/fsp_flash_model.sv
// fsp_flash_model: behavioural program flash array behind the sequencer.
// assumes one command a clock on the sequencer's flash command port.
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.svh"
module fsp_flash_model (
    // clock
    input wire logic sys_clk_i,
    // sequencer side
    input wire fsp_pkg::fsp_flash_s flash_cmd_i,
    input wire logic [15:0] z_ptr_i,
    output logic [15:0] flash_rdata_o
);
    import fsp_pkg::*;
    localparam int WORDS = 1 << (`FSP_PAGE_W + `FSP_WORD_W);
    logic [15:0] mem [0:WORDS-1];
    initial begin
        for (int i = 0; i < WORDS; i++) begin
            mem[i] = 16'hFFFF;
        end
    end
    always @(posedge sys_clk_i) begin
        if (flash_cmd_i.erase) begin
            for (int i = 0; i < (1 << `FSP_WORD_W); i++) begin
                mem[{flash_cmd_i.page, 5'(i)}] <= 16'hFFFF;
            end
        end
        // programming only clears bits, so an unerased page is corrupted
        if (flash_cmd_i.write) begin
            mem[{flash_cmd_i.page, flash_cmd_i.word}] <=
                mem[{flash_cmd_i.page, flash_cmd_i.word}] & flash_cmd_i.data;
        end
    end
    assign flash_rdata_o = mem[z_ptr_i[11:1]];
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// tb_top: self-checking bench of the flash self-program sequencer.
// assumes the rtl package, the sequencer and the flash model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "fsp_map.svh"
module tb_top;
    import fsp_pkg::*;
    // short op time keeps the run brief
    localparam int OPC = 40;
    logic sys_clk_i, resetn_i, we, re, spm, lpm, gie, ee, stall, irq;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, lpm_q, q;
    logic [15:0] z, pair, frd;
    logic [5:0] pg;
    fsp_fuse_s fuse;
    fsp_flash_s fcmd;
    logic [15:0] expw [0:31];
    int miscompares = 0;
    int checks_done = 0;
    int n;

    fsp_seq #(.OP_CYCLES(OPC)) dut_u (
        .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata),
        .spm_exec_i(spm), .lpm_exec_i(lpm), .z_ptr_i(z), .data_word_pair_i(pair),
        .global_irq_en_i(gie), .cpu_stall_o(stall), .lpm_data_o(lpm_q),
        .self_prog_ready_irq_o(irq), .flash_rdata_i(frd),
        .eeprom_write_busy_i(ee), .fuse_prog_i(fuse), .flash_cmd_o(fcmd)
    );
    fsp_flash_model flash_u (
        .sys_clk_i(sys_clk_i), .flash_cmd_i(fcmd), .z_ptr_i(z), .flash_rdata_o(frd)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    // ****************
    // tasks
    // ****************
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge sys_clk_i);
        we <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        re <= 1'b1;
        addr <= a;
        @(posedge sys_clk_i);
        re <= 1'b0;
        // read data stand in the cycle after the strobe; take them at its closing edge
        @(posedge sys_clk_i);
        d = rdata;
    endtask
    task automatic ld(input logic [15:0] zz, output logic [7:0] d);
        @(posedge sys_clk_i);
        lpm <= 1'b1;
        z <= zz;
        @(posedge sys_clk_i);
        lpm <= 1'b0;
        @(posedge sys_clk_i);
        d = lpm_q;
    endtask
    // command write, store two cycles later, then count stalled cycles
    task automatic sp(input logic [7:0] c, input logic [15:0] zz, input logic [15:0] dd);
        wr(`FSP_ADDR_CTRL, c);
        @(posedge sys_clk_i);
        spm <= 1'b1;
        z <= zz;
        pair <= dd;
        @(posedge sys_clk_i);
        spm <= 1'b0;
        n = 0;
        repeat (3) @(posedge sys_clk_i);
        while (stall === 1'b1 && n < 200) begin
            @(posedge sys_clk_i);
            n++;
        end
    endtask
    task automatic er(input logic [5:0] p);
        sp(`FSP_CMD_ERASE, {4'hA, p, 6'h2B}, 16'h5A5A);
        chk("erase stall", 16'(n >= OPC - 4 && n <= OPC + 2), 16'h1);
    endtask
    function automatic logic [7:0] fbyte(input int i);
        case (i)
            0: return ~fuse.low;
            1: return ~fuse.lock;
            2: return ~fuse.ext;
            default: return ~fuse.high;
        endcase
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        miscompares++;
        tally_and_finish();
    end

    // ****************
    // main sequence
    // ****************
    initial begin
        {we, re, spm, lpm, gie, ee, addr, wdata, z, pair, resetn_i} = '0;
        fuse = '0;
        void'($urandom(32'h2254));
        repeat (4) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        rd(`FSP_ADDR_CTRL, q);
        chk("ctrl reset", q, `FSP_CTRL_RST);
        rd(`FSP_ADDR_STAT, q);
        chk("status reset", q, 16'h0);
        rd(4'h9, q);
        chk("unmapped", q, 16'h0);
        $display("test reset done");
        fuse <= $urandom | 32'h0100_0000;
        for (int i = 0; i < 4; i++) begin
            wr(`FSP_ADDR_CTRL, 8'h09);
            ld(16'(i), q);
            chk("fuse byte", q, fbyte(i));
        end
        rd(`FSP_ADDR_CTRL, q);
        chk("ctrl after fuse", q, 16'h0);
        ld(`FSP_Z_LOCK, q);
        chk("plain load", q, 16'hFF);
        $display("test fuse done");
        // pass 0 loads before erase, pass 1 erases first and loads half
        for (int p = 0; p < 2; p++) begin
            pg = 6'($urandom_range(63));
            for (int w = 0; w < 32; w++) expw[w] = 16'hFFFF;
            if (p == 1) er(pg);
            for (int w = 31; w >= 0; w = w - 1 - p) begin
                expw[w] = 16'($urandom);
                sp(`FSP_CMD_LOAD, {4'h0, pg, 5'(w), 1'b0}, expw[w]);
            end
            if (p == 0) er(pg);
            sp(`FSP_CMD_WRITE, {4'h0, pg, 6'h00}, 16'(~$urandom));
            chk("write stall", 16'(n >= OPC - 4 && n <= OPC + 2), 16'h1);
            rd(`FSP_ADDR_CTRL, q);
            chk("enable clear", 16'(q[`FSP_BIT_EN]), 16'h0);
            rd(`FSP_ADDR_STAT, q);
            chk("buffer after write", 16'(q[2]), 16'h0);
            for (int w = 0; w < 32; w++) begin
                for (int b = 0; b < 2; b++) begin
                    ld({4'h0, pg, 5'(w), 1'(b)}, q);
                    chk("flash byte", q, b ? expw[w][15:8] : expw[w][7:0]);
                end
            end
            $display("test program pass %0d done", p);
        end
        sp(`FSP_CMD_LOAD, 16'h0040, 16'h1234);
        rd(`FSP_ADDR_STAT, q);
        chk("buffer loaded", 16'(q[2]), 16'h1);
        ee <= 1'b1;
        @(posedge sys_clk_i);
        ee <= 1'b0;
        rd(`FSP_ADDR_STAT, q);
        chk("eeprom discard", 16'(q[2]), 16'h0);
        sp(`FSP_CMD_LOAD, 16'h0042, 16'h4321);
        wr(`FSP_ADDR_CTRL, 8'h10);
        rd(`FSP_ADDR_STAT, q);
        chk("reenable clear", 16'(q[2]), 16'h0);
        ee <= 1'b1;
        wr(`FSP_ADDR_CTRL, `FSP_CMD_ERASE);
        rd(`FSP_ADDR_CTRL, q);
        chk("ctrl while eeprom", q, 16'h0);
        ee <= 1'b0;
        wr(`FSP_ADDR_CTRL, `FSP_CMD_ERASE);
        repeat (6) @(posedge sys_clk_i);
        rd(`FSP_ADDR_CTRL, q);
        chk("cancel", q, 16'h0);
        @(posedge sys_clk_i);
        spm <= 1'b1;
        @(posedge sys_clk_i);
        spm <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk("late store", 16'(stall), 16'h0);
        // armed erase, but the store lands while the eeprom is busy
        wr(`FSP_ADDR_CTRL, `FSP_CMD_ERASE);
        ee <= 1'b1;
        spm <= 1'b1;
        @(posedge sys_clk_i);
        spm <= 1'b0;
        ee <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        chk("store while eeprom", 16'(stall), 16'h0);
        $display("test refusals done");
        wr(`FSP_ADDR_CTRL, 8'h80);
        gie <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        chk("ready irq", 16'(irq), 16'h1);
        ee <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        chk("irq eeprom", 16'(irq), 16'h0);
        ee <= 1'b0;
        $display("test irq done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
